// ==== hdl/pftm_mapper.sv ====
// path frame source and sink with one tributary mapper and its register slave
//
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/100ps
`default_nettype none

// ============================================================================
module pftm_mapper #(
    parameter int unsigned STORE_DEPTH = 32
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic [pftm_pkg::AXI_AW-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [pftm_pkg::AXI_AW-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic path_timing_clock_i,
    input wire logic path_timing_frame_start_i,
    input wire logic ap_data_i,
    input wire logic operator_user_bit_i,
    input wire logic remote_defect_request_i,
    input wire logic access_grant_i,
    input wire logic tributary_data_in_i,
    input wire logic tributary_clock_in_i,
    output logic tx_data_o,
    output logic tx_frame_start_o,
    output logic tx_bit_strobe_o,
    input wire logic rx_data_i,
    input wire logic rx_clock_i,
    input wire logic rx_frame_start_i,
    input wire logic incoming_server_fail_i,
    input wire logic equipment_defect_i,
    output logic rx_operator_user_bit_o,
    output logic trail_fail_out_o,
    output logic remote_defect_action_o,
    output logic remote_defect_detected_o,
    output logic remote_defect_report_o,
    output logic server_fail_report_o,
    output logic near_block_errored_o,
    output logic near_defect_second_o,
    output logic far_defect_second_o
);
    import pftm_pkg::*;
    localparam int unsigned FW = $clog2(STORE_DEPTH) + 1;
    localparam logic [FW-1:0] JUST_LEVEL = FW'(STORE_DEPTH / 2);
    function automatic pftm_kind_t kind_of(input logic [POS_W-1:0] pos);
        if (pos < POS_RDI) begin
            return K_FAS;
        end else if (pos == POS_RDI) begin
            return K_RDI;
        end else if (pos == POS_NU) begin
            return K_NU;
        end else if ((pos >> 2) == (POS_C1 >> 2) || (pos >> 2) == (POS_C2 >> 2)
                     || (pos >> 2) == (POS_C3 >> 2)) begin
            return K_CTRL;
        end else if ((pos >> 2) == (POS_J >> 2)) begin
            return K_JUST;
        end else begin
            return K_DATA;
        end
    endfunction

    function automatic logic [POS_W-1:0] step_pos(input logic [POS_W-1:0] pos,
                                                  input logic fs);
        if (fs || pos == POS_LAST) begin
            return '0;
        end else begin
            return pos + POS_W'(1);
        end
    endfunction
    function automatic logic align_bit(input logic [POS_W-1:0] pos);
        return ALIGN_PATTERN[ALIGN_MSB - pos[3:0]];
    endfunction

    // ========================================================================
    // input synchronisers and edge finders
    logic [12:0] pins_s;
    logic path_clk_s, path_fs_s, ap_s, nu_s, rdi_req_s, grant_s;
    logic trib_d_s, trib_clk_s, rx_d_s, rx_clk_s, rx_fs_s, ssf_s, eq_s;
    logic path_clk_q, trib_clk_q, rx_clk_q;
    logic path_rise, trib_rise, rx_rise;

    pftm_sync #(
        .W(13)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .async_i({path_timing_clock_i, path_timing_frame_start_i, ap_data_i,
                  operator_user_bit_i, remote_defect_request_i, access_grant_i,
                  tributary_data_in_i, tributary_clock_in_i, rx_data_i, rx_clock_i,
                  rx_frame_start_i, incoming_server_fail_i, equipment_defect_i}),
        .sync_o(pins_s)
    );

    assign {path_clk_s, path_fs_s, ap_s, nu_s, rdi_req_s, grant_s, trib_d_s,
            trib_clk_s, rx_d_s, rx_clk_s, rx_fs_s, ssf_s, eq_s} = pins_s;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            path_clk_q <= 1'b0;
            trib_clk_q <= 1'b0;
            rx_clk_q <= 1'b0;
        end else if (ce_i) begin
            path_clk_q <= path_clk_s;
            trib_clk_q <= trib_clk_s;
            rx_clk_q <= rx_clk_s;
        end
    end

    // every line bit is taken on a rising edge of its own bit clock
    assign path_rise = ce_i && path_clk_s && !path_clk_q;
    assign trib_rise = ce_i && trib_clk_s && !trib_clk_q;
    assign rx_rise = ce_i && rx_clk_s && !rx_clk_q;

    // ========================================================================
    // control register and slot selection
    logic [7:0] ctrl;
    logic [2:0] slot_idx;
    logic drive_slot;

    assign slot_idx = ctrl[CTRL_SLOT_LO +: 3];
    assign drive_slot = ctrl[CTRL_ACT] && grant_s
                        && slot_idx >= SLOT_MIN && slot_idx <= SLOT_MAX;

    // ========================================================================
    // elastic store: tributary bits in, path slot bits out
    logic rd_en, rd_bit, store_empty;
    logic [FW-1:0] fill;

    pftm_estore #(
        .DEPTH(STORE_DEPTH)
    ) u_store (
        .ref_clk_i(ref_clk_i),
        .srst_i(srst_i),
        .ce_i(ce_i),
        .wr_en_i(trib_rise),
        .wr_bit_i(trib_d_s),
        .rd_en_i(rd_en),
        .rd_bit_o(rd_bit),
        .fill_o(fill),
        .empty_o(store_empty)
    );

    // ========================================================================
    // trail source and tributary slot mapping
    logic [POS_W-1:0] tx_pos, next_tx_pos;
    pftm_kind_t tx_kind;
    logic mine, justify, rdi_tx, next_tx_bit, slot_bit;

    assign next_tx_pos = step_pos(tx_pos, path_fs_s);
    assign tx_kind = kind_of(next_tx_pos);
    assign mine = drive_slot && (next_tx_pos[1:0] == 2'(slot_idx - SLOT_MIN));
    // a starved store sends ones instead of stalling the line
    assign slot_bit = store_empty ? 1'b1 : rd_bit;
    assign rd_en = path_rise && mine
                   && (tx_kind == K_DATA || (tx_kind == K_JUST && !justify));

    always_comb begin
        next_tx_bit = ap_s;
        case (tx_kind)
            K_FAS: next_tx_bit = align_bit(next_tx_pos);
            K_RDI: next_tx_bit = rdi_tx;
            K_NU: next_tx_bit = nu_s;
            K_CTRL: next_tx_bit = mine ? justify : ap_s;
            K_JUST: next_tx_bit = mine ? (!justify && slot_bit) : ap_s;
            K_DATA: next_tx_bit = mine ? slot_bit : ap_s;
            default: next_tx_bit = ap_s;
        endcase
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            tx_pos <= POS_LAST;
            tx_data_o <= 1'b1;
            tx_frame_start_o <= 1'b0;
            tx_bit_strobe_o <= 1'b0;
        end else if (ce_i) begin
            tx_bit_strobe_o <= path_rise;
            if (path_rise) begin
                tx_pos <= next_tx_pos;
                tx_data_o <= next_tx_bit;
                tx_frame_start_o <= (next_tx_pos == '0);
            end
        end
    end

    // decisions are taken once per frame so all three control bits agree
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            justify <= 1'b1;
            rdi_tx <= 1'b0;
        end else if (path_rise && next_tx_pos == '0) begin
            justify <= (fill < JUST_LEVEL);
            rdi_tx <= rdi_req_s || ctrl[CTRL_RDI_REQ];
        end
    end

    // ========================================================================
    // trail sink: alignment check, remote defect and performance primitives
    logic [POS_W-1:0] rx_pos, next_rx_pos;
    logic fas_err, fas_miss, nbe;
    logic [2:0] rdi_cnt;
    logic rdi_det;
    logic [31:0] ebc;
    logic ebc_clr;

    assign next_rx_pos = step_pos(rx_pos, rx_fs_s);
    assign fas_miss = (rx_d_s != align_bit(next_rx_pos));

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rx_pos <= POS_LAST;
            fas_err <= 1'b0;
            nbe <= 1'b0;
            rx_operator_user_bit_o <= 1'b0;
        end else if (ce_i) begin
            nbe <= 1'b0;
            if (rx_rise) begin
                rx_pos <= next_rx_pos;
                if (next_rx_pos < POS_RDI) begin
                    fas_err <= ((next_rx_pos != '0) && fas_err) || fas_miss;
                end
                if (next_rx_pos == POS_RDI) begin
                    nbe <= fas_err;
                end
                if (next_rx_pos == POS_NU) begin
                    rx_operator_user_bit_o <= rx_d_s;
                end
            end
        end
    end

    // the state flips only after the opposite value persists
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            rdi_cnt <= '0;
            rdi_det <= 1'b0;
        end else if (rx_rise && next_rx_pos == POS_RDI) begin
            if (rx_d_s == rdi_det) begin
                rdi_cnt <= '0;
            end else if (rdi_cnt == RDI_PERSIST - 3'h1) begin
                rdi_cnt <= '0;
                rdi_det <= rx_d_s;
            end else begin
                rdi_cnt <= rdi_cnt + 3'h1;
            end
        end
    end

    // a block error in the clearing cycle still counts
    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            ebc <= '0;
        end else if (ce_i) begin
            if (ebc_clr) begin
                ebc <= {31'h0, nbe};
            end else begin
                ebc <= ebc + {31'h0, nbe};
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            trail_fail_out_o <= 1'b0;
            remote_defect_action_o <= 1'b0;
            remote_defect_detected_o <= 1'b0;
            remote_defect_report_o <= 1'b0;
            server_fail_report_o <= 1'b0;
            near_block_errored_o <= 1'b0;
            near_defect_second_o <= 1'b0;
            far_defect_second_o <= 1'b0;
        end else if (ce_i) begin
            trail_fail_out_o <= ssf_s;
            remote_defect_action_o <= ssf_s;
            remote_defect_detected_o <= rdi_det;
            remote_defect_report_o <= rdi_det && ctrl[CTRL_MON] && ctrl[CTRL_RDI_EN];
            server_fail_report_o <= ssf_s && ctrl[CTRL_MON] && ctrl[CTRL_SSF_EN];
            near_block_errored_o <= nbe;
            near_defect_second_o <= ssf_s || eq_s;
            far_defect_second_o <= rdi_det;
        end
    end

    // ========================================================================
    // register slave
    logic aw_held, w_held;
    logic [AXI_AW-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;
    logic [31:0] status;

    assign s_axi_awready_o = ce_i && !aw_held;
    assign s_axi_wready_o = ce_i && !w_held;
    assign s_axi_arready_o = ce_i && !s_axi_rvalid_o;
    assign wr_go = ce_i && aw_held && w_held && !s_axi_bvalid_o;
    assign ebc_clr = wr_go && aw_addr == ADDR_EBC && w_strb != 4'h0;
    assign status = {{(24 - FW){1'b0}}, fill, 3'h0, justify, ssf_s,
                     server_fail_report_o, remote_defect_report_o, rdi_det};

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end else if (ce_i) begin
            if (s_axi_awvalid_i && !aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr_i;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid_i && !w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata_i;
                w_strb <= s_axi_wstrb_i;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            ctrl <= CTRL_RESET;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
        end else if (ce_i) begin
            if (wr_go) begin
                s_axi_bvalid_o <= 1'b1;
                s_axi_bresp_o <= (aw_addr == ADDR_CTRL || aw_addr == ADDR_STATUS
                                  || aw_addr == ADDR_EBC) ? RESP_OKAY : RESP_SLVERR;
                if (aw_addr == ADDR_CTRL && w_strb[0]) begin
                    ctrl <= w_data[7:0];
                end
            end else if (s_axi_bready_i) begin
                s_axi_bvalid_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= '0;
            s_axi_rresp_o <= RESP_OKAY;
        end else if (ce_i) begin
            if (s_axi_arvalid_i && !s_axi_rvalid_o) begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rresp_o <= RESP_OKAY;
                case (s_axi_araddr_i)
                    ADDR_CTRL: s_axi_rdata_o <= {24'h0, ctrl};
                    ADDR_STATUS: s_axi_rdata_o <= status;
                    ADDR_EBC: s_axi_rdata_o <= ebc;
                    default: begin
                        s_axi_rdata_o <= '0;
                        s_axi_rresp_o <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready_i) begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end
endmodule // pftm_mapper

`default_nettype wire

// ==== hdl/pftm_pkg.sv ====
// constants and types shared by the path frame mapper design
package pftm_pkg;
    // ========================================================================
    // frame layout, bit positions counted from 0 at frame start
    localparam int unsigned POS_W = 11;
    localparam logic [10:0] POS_LAST = 11'h5ff;
    localparam logic [10:0] POS_RDI = 11'h00a;
    localparam logic [10:0] POS_NU = 11'h00b;
    localparam logic [10:0] POS_C1 = 11'h180;
    localparam logic [10:0] POS_C2 = 11'h300;
    localparam logic [10:0] POS_C3 = 11'h480;
    localparam logic [10:0] POS_J = 11'h484;
    localparam logic [9:0] ALIGN_PATTERN = 10'h3d0;
    localparam logic [3:0] ALIGN_MSB = 4'h9;
    localparam logic [2:0] SLOT_MIN = 3'h1;
    localparam logic [2:0] SLOT_MAX = 3'h4;
    localparam logic [2:0] RDI_PERSIST = 3'h5;

    // ========================================================================
    // register map
    localparam int unsigned AXI_AW = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_EBC = 8'h08;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam int unsigned CTRL_MON = 0;
    localparam int unsigned CTRL_RDI_EN = 1;
    localparam int unsigned CTRL_SSF_EN = 2;
    localparam int unsigned CTRL_ACT = 3;
    localparam int unsigned CTRL_SLOT_LO = 4;
    localparam int unsigned CTRL_RDI_REQ = 7;
    localparam int unsigned STAT_FILL_LO = 8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [5:0] {
        K_FAS = 6'h01,
        K_RDI = 6'h02,
        K_NU = 6'h04,
        K_CTRL = 6'h08,
        K_JUST = 6'h10,
        K_DATA = 6'h20
    } pftm_kind_t;
endpackage

// ==== hdl/pftm_sync.sv ====
// two-stage synchroniser for a group of asynchronous inputs
`timescale 1ns/100ps
`default_nettype none

module pftm_sync #(
    parameter int unsigned W = 1
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta;

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            meta <= '0;
            sync_o <= '0;
        end else if (ce_i) begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule // pftm_sync

`default_nettype wire

// ==== hdl/pftm_estore.sv ====
// single-bit elastic store between tributary writes and path reads
`timescale 1ns/100ps
`default_nettype none

module pftm_estore #(
    parameter int unsigned DEPTH = 32
) (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic wr_en_i,
    input wire logic wr_bit_i,
    input wire logic rd_en_i,
    output logic rd_bit_o,
    output logic [$clog2(DEPTH):0] fill_o,
    output logic empty_o
);
    localparam int unsigned AW = $clog2(DEPTH);

    if (DEPTH < 8 || DEPTH > 256 || (1 << AW) != DEPTH) begin : g_chk
        $error("store depth must be a power of two from 8 to 256");
    end

    logic [DEPTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic do_wr;
    logic do_rd;

    // a write into a full store is dropped rather than corrupting the head
    assign do_wr = wr_en_i && (fill_o != (AW+1)'(DEPTH));
    assign do_rd = rd_en_i && !empty_o;
    assign empty_o = (fill_o == '0);
    assign rd_bit_o = mem[rd_ptr];

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            mem <= '0;
        end else if (ce_i && do_wr) begin
            mem[wr_ptr] <= wr_bit_i;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (srst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill_o <= '0;
        end else if (ce_i) begin
            wr_ptr <= wr_ptr + AW'(do_wr);
            rd_ptr <= rd_ptr + AW'(do_rd);
            fill_o <= fill_o + (AW+1)'(do_wr) - (AW+1)'(do_rd);
        end
    end
endmodule // pftm_estore

`default_nettype wire

// ==== bench/pftm_mapper_properties.sv ====
// port checker for the path frame mapper
`timescale 1ns/100ps
`default_nettype none
module pftm_mapper_properties (
    input wire logic ref_clk_i,
    input wire logic srst_i,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [31:0] s_axi_rdata_o,
    input wire logic s_axi_arready_o,
    input wire logic tx_data_o,
    input wire logic tx_bit_strobe_o,
    input wire logic trail_fail_out_o,
    input wire logic remote_defect_detected_o,
    input wire logic remote_defect_report_o,
    input wire logic server_fail_report_o,
    input wire logic near_block_errored_o
);
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (srst_i);
    // ========================================
    // bus answers
    bresp_hold_a:
        assert property (s_axi_bvalid_o && !s_axi_bready_i
            |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("bresp dropped");
    rdata_hold_a:
        assert property (s_axi_rvalid_o && !s_axi_rready_i
            |=> s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("rdata dropped");
    ar_block_a:
        assert property (s_axi_rvalid_o |-> !s_axi_arready_o) else $error("arready in read");
    // ========================================
    // line side; one bit period spans 32 clocks, so 8 quiet cycles is safe
    bit_strobe_a:
        assert property ($changed(tx_data_o) |-> tx_bit_strobe_o) else $error("bit unstrobed");
    strobe_gap_a:
        assert property (tx_bit_strobe_o |=> !tx_bit_strobe_o [*8]) else $error("strobe gap");
    block_pulse_a:
        assert property (near_block_errored_o |=> !near_block_errored_o [*8])
            else $error("errored pulse repeated");
    rdi_report_a:
        assert property (remote_defect_report_o |-> remote_defect_detected_o)
            else $error("report without defect");
    ssf_report_a:
        assert property (server_fail_report_o |-> trail_fail_out_o)
            else $error("report without fail");
endmodule // pftm_mapper_properties

bind pftm_mapper pftm_mapper_properties u_props (
    .ref_clk_i(ref_clk_i), .srst_i(srst_i), .s_axi_bvalid_o(s_axi_bvalid_o),
    .s_axi_bready_i(s_axi_bready_i), .s_axi_bresp_o(s_axi_bresp_o),
    .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
    .s_axi_rdata_o(s_axi_rdata_o), .s_axi_arready_o(s_axi_arready_o),
    .tx_data_o(tx_data_o), .tx_bit_strobe_o(tx_bit_strobe_o),
    .trail_fail_out_o(trail_fail_out_o), .remote_defect_detected_o(remote_defect_detected_o),
    .remote_defect_report_o(remote_defect_report_o),
    .server_fail_report_o(server_fail_report_o), .near_block_errored_o(near_block_errored_o)
);
`default_nettype wire

// ==== bench/pftm_far_end.sv ====
// far-end model: path timing, tributary source and receive loopback
`timescale 1ns/100ps
`default_nettype none
module pftm_far_end (
    input wire logic ref_clk_i,
    input wire logic run_i,
    input wire logic err_i,
    input wire logic tx_data_i,
    input wire logic tx_fs_i,
    input wire logic tx_stb_i,
    output logic pclk_o,
    output logic pfs_o,
    output logic trib_clk_o,
    output logic trib_data_o,
    output logic rx_data_o
);
    int pcnt = 0;
    int tpos = 0;
    initial begin
        pclk_o = 1'b0;
        pfs_o = 1'b1;
        trib_clk_o = 1'b0;
    end
    // ========================================
    // clocks stand still until the run starts; tributary scaled to the 160 ns path bit
    always #80 if (run_i) pclk_o = ~pclk_o;
    always #(trib_clk_o ? 325.5 : 325.4) if (run_i) trib_clk_o = ~trib_clk_o;
    // all-ones tributary makes every slot bit predictable
    assign trib_data_o = 1'b1;
    always @(negedge pclk_o) pfs_o = (pcnt == 0);
    always @(posedge pclk_o) pcnt = (pcnt == 1535) ? 0 : pcnt + 1;
    // ========================================
    // loopback with one alignment bit spoiled on request
    always @(posedge ref_clk_i) if (tx_stb_i) tpos <= tx_fs_i ? 0 : tpos + 1;
    assign rx_data_o = tx_data_i ^ (err_i && tpos == 3);
endmodule // pftm_far_end
`default_nettype wire

// ==== bench/pftm_mapper_tb_top.sv ====
// testbench for the path frame mapper
`timescale 1ns/100ps
`default_nettype none
module pftm_mapper_tb_top;
    import pftm_pkg::*;
    logic clk = 1'b0, srst = 1'b1, rdreq = 1'b0, ssf = 1'b0, eqd = 1'b0, run = 1'b0, err = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0, gnt = 1'b1;
    logic awready, wready, bvalid, arready, rvalid, txd, txfs, stb, pclk, pfs, tclk, tdat, rxd;
    logic rxnu, tfo, rda, rrep, srep, nds;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic fb [0:1535];
    logic cb [0:1535];
    int pos = 0, frames = -1, error_cnt = 0, cmp_count = 0, cyc = 0;

    pftm_mapper #(.STORE_DEPTH(32)) dut (
        .ref_clk_i(clk), .srst_i(srst), .ce_i(1'b1),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
        .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .path_timing_clock_i(pclk),
        .path_timing_frame_start_i(pfs), .ap_data_i(1'b0), .operator_user_bit_i(err),
        .remote_defect_request_i(rdreq), .access_grant_i(gnt),
        .tributary_data_in_i(tdat), .tributary_clock_in_i(tclk), .tx_data_o(txd),
        .tx_frame_start_o(txfs), .tx_bit_strobe_o(stb), .rx_data_i(rxd), .rx_clock_i(pclk),
        .rx_frame_start_i(txfs), .incoming_server_fail_i(ssf), .equipment_defect_i(eqd),
        .rx_operator_user_bit_o(rxnu), .trail_fail_out_o(tfo), .remote_defect_action_o(rda),
        .remote_defect_detected_o(), .remote_defect_report_o(rrep),
        .server_fail_report_o(srep), .near_block_errored_o(), .near_defect_second_o(nds),
        .far_defect_second_o()
    );
    pftm_far_end far (
        .ref_clk_i(clk), .run_i(run), .err_i(err), .tx_data_i(txd), .tx_fs_i(txfs),
        .tx_stb_i(stb), .pclk_o(pclk), .pfs_o(pfs), .trib_clk_o(tclk), .trib_data_o(tdat),
        .rx_data_o(rxd)
    );

    initial begin
        forever #2.5 clk = ~clk;
    end
    // ========================================
    // transmit capture, one frame kept whole
    always @(posedge clk) begin
        if (stb === 1'b1) begin
            if (txfs) begin
                fb = cb;
                frames = frames + 1;
            end
            pos = txfs ? 0 : pos + 1;
            if (pos < 1536) cb[pos] = txd;
        end
    end
    // two frames of 1536 bits at 32 clocks a bit, plus margin
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 110000) begin
            error_cnt = error_cnt + 1;
            finish_test();
        end
    end
    // ========================================
    // shared tasks
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", er, bresp);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        chk("rdata", d, rdata);
        chk("rresp", er, rresp);
    endtask
    task automatic finish_test();
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ========================================
    // scenarios
    task automatic t_regs();
        rd(ADDR_CTRL, 32'h0, RESP_OKAY);
        rd(ADDR_EBC, 32'h0, RESP_OKAY);
        wr(ADDR_CTRL, 32'hffff_ff2f, 4'hf, RESP_OKAY);
        wr(ADDR_CTRL, 32'h0000_0007, 4'he, RESP_OKAY);
        rd(ADDR_CTRL, 32'h2f, RESP_OKAY);
        wr(8'h0c, 32'h1, 4'hf, RESP_SLVERR);
        rd(8'h0c, 32'h0, RESP_SLVERR);
    endtask
    task automatic t_fail();
        wr(ADDR_CTRL, 32'h07, 4'h1, RESP_OKAY);
        ssf <= 1'b1;
        repeat (8) @(posedge clk);
        chk("trail fail", 1'b1, tfo);
        chk("defect action", 1'b1, rda);
        chk("fail report", 1'b1, srep);
        chk("near second", 1'b1, nds);
        wr(ADDR_CTRL, 32'h06, 4'h1, RESP_OKAY);
        repeat (4) @(posedge clk);
        chk("report unmonitored", 1'b0, srep);
        ssf <= 1'b0;
        eqd <= 1'b1;
        repeat (8) @(posedge clk);
        chk("trail fail off", 1'b0, tfo);
        chk("equipment second", 1'b1, nds);
        chk("defect report", 1'b0, rrep);
        eqd <= 1'b0;
        wr(ADDR_CTRL, 32'h00, 4'h1, RESP_OKAY);
    endtask
    task automatic t_link();
        rdreq <= 1'b1;
        run <= 1'b1;
        wait (pos == 768);
        gnt <= 1'b0;
        wr(ADDR_CTRL, 32'h2f, 4'h1, RESP_OKAY);
        wait (frames == 1);
        err <= 1'b1;
        gnt <= 1'b1;
        for (int i = 0; i < 10; i++) chk("align", ALIGN_PATTERN[9-i], fb[i]);
        chk("defect bit", 1'b1, fb[10]);
        chk("user bit", 1'b0, fb[11]);
        for (int i = 12; i < 1536; i++) chk("idle", 1'b0, fb[i]);
        wait (frames == 2);
        err <= 1'b0;
        chk("rx user bit", 1'b1, rxnu);
        chk("control known", 1'b0, $isunknown(fb[385]));
        chk("control 2", fb[385], fb[769]);
        chk("control 3", fb[385], fb[1153]);
        chk("opportunity", !fb[385], fb[1157]);
        for (int i = 12; i < 1536; i++) begin
            if (i % 4 != 1) chk("other slot", 1'b0, fb[i]);
            else if (!(i inside {385, 769, 1153, 1157})) chk("slot", 1'b1, fb[i]);
        end
        rd(ADDR_EBC, 32'h1, RESP_OKAY);
        wr(ADDR_EBC, 32'h0, 4'hf, RESP_OKAY);
        rd(ADDR_EBC, 32'h0, RESP_OKAY);
    endtask

    initial begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_fail();
        t_link();
        finish_test();
    end
endmodule // pftm_mapper_tb_top
`default_nettype wire
